// ### src/pmt_consts.vh
// constants for the paged memory map translator
`ifndef PMT_CONSTS_VH
`define PMT_CONSTS_VH

// register indexes as printed; byte address is four times the index
`define PMT_IDX_ZERO_PAGE_BASE   8'h11
`define PMT_IDX_PROG_WINDOW      8'h30
`define PMT_IDX_DEBUG_WINDOW     8'h31
`define PMT_IDX_STATUS           8'h32
`define PMT_ADDR_ZERO_PAGE_BASE  10'h044
`define PMT_ADDR_PROG_WINDOW     10'h0c0
`define PMT_ADDR_DEBUG_WINDOW    10'h0c4
`define PMT_ADDR_STATUS          10'h0c8
`define PMT_ADDR_W               10

// reset values
`define PMT_RST_ZERO_PAGE_BASE   8'h00
`define PMT_RST_PROG_WINDOW      4'he
`define PMT_RST_DEBUG_WINDOW     4'h0

// field positions
`define PMT_PWB_MSB              3
`define PMT_DBG_EN_BIT           4
`define PMT_ST_LOCK_BIT          0
`define PMT_ST_SPECIAL_BIT       1
`define PMT_ST_DEBUG_BIT         2

// fixed pages of the local map
`define PMT_PAGE_LOW             4'hc
`define PMT_PAGE_MID             4'hd
`define PMT_PAGE_TOP             4'hf
`define PMT_PAGE_INFO            4'h1

// global map
`define PMT_REG_TOP              18'h003ff
`define PMT_RAM_TOP_PLUS1        18'h04000
`define PMT_RAM_BYTE_COUNT       18'h02c00
`define PMT_DFL_LOW              18'h04400
`define PMT_DFL_TOP              18'h053ff
`define PMT_INFO_LOW             18'h04000
`define PMT_INFO_TOP             18'h07fff
`define PMT_PFL_TOP_PLUS1        19'h40000
`define PMT_PFL_BYTE_COUNT       19'h38000
`define PMT_DFL_LOCAL_LOW        16'h0400
`define PMT_DFL_LOCAL_TOP        16'h13ff
`define PMT_DFL_LOCAL_SHIFT      18'h04000
`define PMT_DBG_LOCAL_HI         16'hff00
`define PMT_DBG_LOCAL_WIN        16'hbf00

// target select codes
`define PMT_SEL_NONE             3'h0
`define PMT_SEL_REG              3'h1
`define PMT_SEL_RAM              3'h2
`define PMT_SEL_DFLASH           3'h3
`define PMT_SEL_INFO             3'h4
`define PMT_SEL_PFLASH           3'h5
`define PMT_SEL_DEBUG            3'h6

// bus responses
`define PMT_RESP_OKAY            2'b00
`define PMT_RESP_SLVERR          2'b10

`endif

// ### src/pmt_translator.v
// paged memory map translator: direct page, program window, debug overlay, global decode
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
// Notes on behaviour
// - direct accesses take local bits 15:8 from zero page base, reset zero
// - the 256 byte direct window applies to both mapping schemes
// - zero page base always readable; free writes in special, once in normal
// - four-bit program index pages a 16 kB block into 0x8000-0xBFFF
// - program index sits in bits 3:0, readable and writable anytime
// - far call/return index writes complete before the instruction ends
// - local 0x0000-0x3FFF is page 0x0C, overlaid by registers, data flash, RAM
// - local 0x4000-0x7FFF is page 0x0D, 0xC000-0xFFFF page 0x0F
// - program index resets to 0x0E giving linear flash
// - normal mode runs application code, no external bus
// - special mode: active debug state controls execution
// - debug resources decode only in debug read/write cycles
// - active debug shows debug resources at 0xFF00-0xFFFF, hiding others
// - active debug also shows them at 0xBF00-0xBFFF when index is 0x0F
// - debug unit addresses expand like the CPU with a debug page index
// - debug index used only when enabled and during debug commands
// - registers decode at global 0x0_0000-0x0_03FF
// - RAM spans 0x0_4000 minus RAM size up to 0x0_3FFF
// - data flash decodes at global 0x0_4400-0x0_53FF
// - program flash spans 0x4_0000 minus flash size up to 0x3_FFFF
// - information row and data flash are reached through page 0x01
// - CPU access to unimplemented space resets, except firmware commands; debug unit gets undefined data
// - RAM and flash sizes are byte counts
`include "pmt_consts.vh"

module pmt_translator (
   // clock and reset
   input  wire        clk,
   input  wire        rst_n,
   // axi4-lite slave
   input  wire [9:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [9:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // mode and debug state
   input  wire        special_mode,
   input  wire        debug_active,
   input  wire        debug_read_cycle,
   input  wire        debug_write_cycle,
   // far call / return index path
   input  wire        far_wr_valid,
   input  wire [3:0]  far_wr_data,
   output reg         far_wr_done,
   output reg  [3:0]  far_rd_data,
   // cpu access
   input  wire        cpu_valid,
   input  wire [15:0] cpu_addr,
   input  wire        cpu_direct,
   input  wire        cpu_firmware,
   output reg         cpu_out_valid,
   output reg  [17:0] cpu_gaddr,
   output reg  [2:0]  cpu_sel,
   output reg         illegal_access_reset,
   // debug unit access
   input  wire        dbg_valid,
   input  wire [15:0] dbg_addr,
   input  wire        dbg_command,
   output reg         dbg_out_valid,
   output reg  [17:0] dbg_gaddr,
   output reg  [2:0]  dbg_sel,
   output reg         dbg_data_undefined
);

   //---------------------------------------------
   // register state
   //---------------------------------------------
   reg  [7:0] zero_page_base_q;
   reg        zpb_locked_q;
   reg  [3:0] program_window_index_q;
   reg  [3:0] debug_window_index_q;
   reg        debug_window_en_q;

   reg        aw_have_q;
   reg  [9:0] aw_addr_q;
   reg        w_have_q;
   reg [31:0] w_data_q;
   reg  [3:0] w_strb_q;

   wire       wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
   wire       debug_cycle = debug_active && (debug_read_cycle || debug_write_cycle);

   //---------------------------------------------
   // translation functions
   //---------------------------------------------
   // local to global expansion shared by both masters
   function [17:0] expand;
      input [15:0] la;
      input [3:0]  page;
      begin
         case (la[15:14])
            2'b00: begin
               if ({2'b00, la} <= `PMT_REG_TOP)
                  expand = {2'b00, la};
               else if ({2'b00, la} >= `PMT_RAM_TOP_PLUS1 - `PMT_RAM_BYTE_COUNT)
                  expand = {2'b00, la};
               else if (la >= `PMT_DFL_LOCAL_LOW && la <= `PMT_DFL_LOCAL_TOP)
                  expand = {2'b00, la} + `PMT_DFL_LOCAL_SHIFT;
               else
                  expand = {`PMT_PAGE_LOW, la[13:0]};
            end
            2'b01:   expand = {`PMT_PAGE_MID, la[13:0]};
            2'b10:   expand = {page, la[13:0]};
            default: expand = {`PMT_PAGE_TOP, la[13:0]};
         endcase
      end
   endfunction

   // global decode into a target, with the debug overlay on top
   function [2:0] decode;
      input [17:0] ga;
      input [15:0] la;
      input [3:0]  page;
      input        dbg_vis;
      begin
         if (dbg_vis && (la >= `PMT_DBG_LOCAL_HI ||
             (la[15:14] == 2'b10 && page == `PMT_PAGE_TOP && la >= `PMT_DBG_LOCAL_WIN)))
            decode = `PMT_SEL_DEBUG;
         else if (ga <= `PMT_REG_TOP)
            decode = `PMT_SEL_REG;
         else if (ga >= `PMT_RAM_TOP_PLUS1 - `PMT_RAM_BYTE_COUNT && ga < `PMT_RAM_TOP_PLUS1)
            decode = `PMT_SEL_RAM;
         else if (ga >= `PMT_DFL_LOW && ga <= `PMT_DFL_TOP)
            decode = `PMT_SEL_DFLASH;
         else if (ga >= `PMT_INFO_LOW && ga <= `PMT_INFO_TOP)
            decode = `PMT_SEL_INFO;
         else if ({1'b0, ga} >= `PMT_PFL_TOP_PLUS1 - `PMT_PFL_BYTE_COUNT)
            decode = `PMT_SEL_PFLASH;
         else
            decode = `PMT_SEL_NONE;
      end
   endfunction

   //---------------------------------------------
   // master address paths
   //---------------------------------------------
   wire [15:0] cpu_local = cpu_direct ? {zero_page_base_q, cpu_addr[7:0]} : cpu_addr;
   wire [17:0] cpu_g     = expand(cpu_local, program_window_index_q);
   wire [2:0]  cpu_s     = decode(cpu_g, cpu_local, program_window_index_q, debug_cycle);

   // debug index only while enabled and a debug command runs
   wire [3:0]  dbg_page  = (debug_window_en_q && dbg_command) ?
                           debug_window_index_q : program_window_index_q;
   wire [17:0] dbg_g     = expand(dbg_addr, dbg_page);
   wire [2:0]  dbg_s     = decode(dbg_g, dbg_addr, dbg_page, debug_cycle);

   always @(posedge clk) begin
      if (!rst_n) begin
         cpu_out_valid        <= 1'b0;
         cpu_gaddr            <= 18'h00000;
         cpu_sel              <= `PMT_SEL_NONE;
         illegal_access_reset <= 1'b0;
         dbg_out_valid        <= 1'b0;
         dbg_gaddr            <= 18'h00000;
         dbg_sel              <= `PMT_SEL_NONE;
         dbg_data_undefined   <= 1'b0;
      end else begin
         cpu_out_valid        <= cpu_valid;
         cpu_gaddr            <= cpu_g;
         cpu_sel              <= cpu_s;
         // firmware commands are exempt from the reset
         illegal_access_reset <= cpu_valid && !cpu_firmware && cpu_s == `PMT_SEL_NONE;
         dbg_out_valid        <= dbg_valid;
         dbg_gaddr            <= dbg_g;
         dbg_sel              <= dbg_s;
         dbg_data_undefined   <= dbg_valid && dbg_s == `PMT_SEL_NONE;
      end
   end

   //---------------------------------------------
   // axi4-lite write channel
   //---------------------------------------------
   always @(posedge clk) begin
      if (!rst_n) begin
         aw_have_q     <= 1'b0;
         aw_addr_q     <= 10'h000;
         w_have_q      <= 1'b0;
         w_data_q      <= 32'h00000000;
         w_strb_q      <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `PMT_RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready  <= !w_have_q && !(s_axi_wvalid && s_axi_wready);
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_have_q    <= 1'b0;
            w_have_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            case ({aw_addr_q[9:2], 2'b00})
               `PMT_ADDR_ZERO_PAGE_BASE,
               `PMT_ADDR_PROG_WINDOW,
               `PMT_ADDR_DEBUG_WINDOW,
               `PMT_ADDR_STATUS: s_axi_bresp <= `PMT_RESP_OKAY;
               default:          s_axi_bresp <= `PMT_RESP_SLVERR;
            endcase
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   //---------------------------------------------
   // control registers
   //---------------------------------------------
   wire lane0_wr = wr_go && w_strb_q[0];
   wire [9:0] wr_word = {aw_addr_q[9:2], 2'b00};

   always @(posedge clk) begin
      if (!rst_n) begin
         zero_page_base_q       <= `PMT_RST_ZERO_PAGE_BASE;
         zpb_locked_q           <= 1'b0;
         program_window_index_q <= `PMT_RST_PROG_WINDOW;
         debug_window_index_q   <= `PMT_RST_DEBUG_WINDOW;
         debug_window_en_q      <= 1'b0;
         far_wr_done            <= 1'b0;
         far_rd_data            <= `PMT_RST_PROG_WINDOW;
      end else begin
         far_wr_done <= far_wr_valid;
         // special mode never locks; normal mode locks on its first write
         if (lane0_wr && wr_word == `PMT_ADDR_ZERO_PAGE_BASE && (special_mode || !zpb_locked_q)) begin
            zero_page_base_q <= w_data_q[7:0];
            if (!special_mode)
               zpb_locked_q <= 1'b1;
         end
         // far call/return owns the index that cycle over a bus write
         if (far_wr_valid)
            program_window_index_q <= far_wr_data;
         else if (lane0_wr && wr_word == `PMT_ADDR_PROG_WINDOW)
            program_window_index_q <= w_data_q[`PMT_PWB_MSB:0];
         far_rd_data <= far_wr_valid ? far_wr_data : program_window_index_q;
         if (lane0_wr && wr_word == `PMT_ADDR_DEBUG_WINDOW) begin
            debug_window_index_q <= w_data_q[3:0];
            debug_window_en_q    <= w_data_q[`PMT_DBG_EN_BIT];
         end
      end
   end

   //---------------------------------------------
   // axi4-lite read channel
   //---------------------------------------------
   reg [31:0] rd_mux;
   reg        rd_hit;

   always @* begin
      rd_mux = 32'h00000000;
      rd_hit = 1'b1;
      case ({s_axi_araddr[9:2], 2'b00})
         `PMT_ADDR_ZERO_PAGE_BASE: rd_mux[7:0] = zero_page_base_q;
         `PMT_ADDR_PROG_WINDOW:    rd_mux[3:0] = program_window_index_q;
         `PMT_ADDR_DEBUG_WINDOW:   rd_mux[4:0] = {debug_window_en_q, debug_window_index_q};
         `PMT_ADDR_STATUS: begin
            rd_mux[`PMT_ST_LOCK_BIT]    = zpb_locked_q;
            rd_mux[`PMT_ST_SPECIAL_BIT] = special_mode;
            rd_mux[`PMT_ST_DEBUG_BIT]   = debug_active;
         end
         default: rd_hit = 1'b0;
      endcase
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `PMT_RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= rd_hit ? `PMT_RESP_OKAY : `PMT_RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule // pmt_translator

// ### tb/pmt_translator_monitor.sv
// concurrent checks on the translator top-level ports
`timescale 1ns/100ps
`include "pmt_consts.vh"
module pmt_translator_monitor (
   // clock and reset
   input wire        clk,
   input wire        rst_n,
   // mode and debug state
   input wire        debug_active,
   input wire        debug_read_cycle,
   input wire        debug_write_cycle,
   // far path
   input wire        far_wr_valid,
   input wire        far_wr_done,
   // cpu access
   input wire        cpu_valid,
   input wire [15:0] cpu_addr,
   input wire        cpu_direct,
   input wire        cpu_firmware,
   input wire        cpu_out_valid,
   input wire [17:0] cpu_gaddr,
   input wire [2:0]  cpu_sel,
   input wire        illegal_access_reset
);
   wire dbg_cyc = debug_read_cycle | debug_write_cycle;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   AST_OUT_VALID: assert property (cpu_valid |=> cpu_out_valid) else $error("no translation answer");
   AST_MID_PAGE: assert property (cpu_valid && !cpu_direct && cpu_addr[15:14] == 2'b01
      |=> cpu_gaddr == {4'hd, $past(cpu_addr[13:0])}) else $error("middle block page wrong");
   AST_TOP_PAGE: assert property (cpu_valid && !cpu_direct && cpu_addr[15:8] < 8'hff && cpu_addr[15:14] == 2'b11
      |=> cpu_gaddr == {4'hf, $past(cpu_addr[13:0])}) else $error("top block page wrong");
   AST_REG_SPACE: assert property (cpu_valid && !cpu_direct && cpu_addr < 16'h0400
      |=> cpu_sel == `PMT_SEL_REG && cpu_gaddr == {2'b00, $past(cpu_addr)}) else $error("register decode wrong");
   AST_DFL_SPACE: assert property (cpu_valid && !cpu_direct && cpu_addr >= 16'h0400 && cpu_addr <= 16'h13ff
      |=> cpu_sel == `PMT_SEL_DFLASH && cpu_gaddr == {2'b00, $past(cpu_addr)} + 18'h04000)
      else $error("data flash decode wrong");
   AST_DBG_HIDDEN: assert property (cpu_valid && !dbg_cyc |=> cpu_sel != `PMT_SEL_DEBUG)
      else $error("debug area visible outside debug cycles");
   AST_DBG_SHOWN: assert property (cpu_valid && !cpu_direct && debug_active && dbg_cyc && cpu_addr[15:8] == 8'hff
      |=> cpu_sel == `PMT_SEL_DEBUG) else $error("debug area not shown");
   // back-to-back far writes keep done high, so compare with the previous request
   AST_FAR_DONE: assert property (far_wr_valid |=> far_wr_done ##1 far_wr_done == $past(far_wr_valid))
      else $error("far write done late");
   AST_ILLEGAL: assert property (illegal_access_reset |-> cpu_sel == `PMT_SEL_NONE && $past(cpu_valid && !cpu_firmware))
      else $error("illegal access reset without cause");
endmodule // pmt_translator_monitor
bind pmt_translator pmt_translator_monitor u_mon (.clk(clk), .rst_n(rst_n), .debug_active(debug_active),
   .debug_read_cycle(debug_read_cycle), .debug_write_cycle(debug_write_cycle), .far_wr_valid(far_wr_valid),
   .far_wr_done(far_wr_done), .cpu_valid(cpu_valid), .cpu_addr(cpu_addr), .cpu_direct(cpu_direct),
   .cpu_firmware(cpu_firmware), .cpu_out_valid(cpu_out_valid), .cpu_gaddr(cpu_gaddr), .cpu_sel(cpu_sel),
   .illegal_access_reset(illegal_access_reset));

// ### tb/pmt_master_model.sv
// bus master model: cpu and debug unit accesses, far call index path
`timescale 1ns/100ps
module pmt_master_model (
   // clock
   input  wire        clk,
   // masters
   output reg         cpu_valid,
   output reg  [15:0] cpu_addr,
   output reg         cpu_direct,
   output reg         cpu_firmware,
   output reg         dbg_valid,
   output reg  [15:0] dbg_addr,
   // far path
   output reg         far_wr_valid,
   output reg  [3:0]  far_wr_data
);
   initial begin
      {cpu_valid, cpu_direct, cpu_firmware, dbg_valid, far_wr_valid} = 5'h00;
      cpu_addr = 16'h0000;
      dbg_addr = 16'h0000;
      far_wr_data = 4'h0;
   end
   // released lines show the inverse so a stale copy is never mistaken for a request
   task access(input [15:0] a, input d, input f);
      begin
         @(posedge clk);
         {cpu_valid, dbg_valid, cpu_direct, cpu_firmware} <= {2'b11, d, f};
         cpu_addr <= a;
         dbg_addr <= a;
         @(posedge clk);
         {cpu_valid, dbg_valid} <= 2'b00;
         cpu_addr <= ~a;
         dbg_addr <= ~a;
      end
   endtask
   task far(input [3:0] v);
      begin
         @(posedge clk);
         far_wr_valid <= 1'b1;
         far_wr_data <= v;
         @(posedge clk);
         far_wr_valid <= 1'b0;
         far_wr_data <= ~v;
      end
   endtask
endmodule // pmt_master_model

// ### tb/test_pmt_translator.sv
// self-checking bench for the paged memory map translator
`timescale 1ns/100ps
`include "pmt_consts.vh"
module test_pmt_translator;
   reg clk, rst_n, awv, wv, bre, arv, rre, spm, dact, drc, dwc, dcmd;
   reg [9:0] awa, ara;
   reg [31:0] wd, rd;
   reg [1:0] rr, wrsp;
   int err_count, n_tests;
   wire aw_r, w_r, bv, ar_r, rv, cv, cd, cf, dv, fv, fdone, ill, dund, dov;
   wire [1:0] br, rrs;
   wire [31:0] rdat;
   wire [15:0] ca, da;
   wire [3:0] fd, frd;
   wire [17:0] cg, dg;
   wire [2:0] cs, ds;
   pmt_master_model u_pmt_master_model (.clk(clk), .cpu_valid(cv), .cpu_addr(ca), .cpu_direct(cd),
      .cpu_firmware(cf), .dbg_valid(dv), .dbg_addr(da), .far_wr_valid(fv), .far_wr_data(fd));
   pmt_translator u_pmt_translator (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(aw_r), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(w_r),
      .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(ar_r), .s_axi_rdata(rdat), .s_axi_rresp(rrs), .s_axi_rvalid(rv), .s_axi_rready(rre),
      .special_mode(spm), .debug_active(dact), .debug_read_cycle(drc), .debug_write_cycle(dwc),
      .far_wr_valid(fv), .far_wr_data(fd), .far_wr_done(fdone), .far_rd_data(frd), .cpu_valid(cv),
      .cpu_addr(ca), .cpu_direct(cd), .cpu_firmware(cf), .cpu_out_valid(), .cpu_gaddr(cg), .cpu_sel(cs),
      .illegal_access_reset(ill), .dbg_valid(dv), .dbg_addr(da), .dbg_command(dcmd), .dbg_out_valid(dov),
      .dbg_gaddr(dg), .dbg_sel(ds), .dbg_data_undefined(dund));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task finish_test;
      begin
         $display("checks %0d mismatches %0d", n_tests, err_count);
         if (err_count == 0 && n_tests > 0) $display("Run complete: PASS");
         else $display("Run complete: FAIL");
         $finish;
      end
   endtask
   task chk(input string nm, input [31:0] seen, input [31:0] exp);
      begin
         n_tests++;
         if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   task tmo;
      begin
         err_count++;
         finish_test;
      end
   endtask
   task wr(input [9:0] a, input [31:0] d);
      int i;
      begin
         @(posedge clk);
         {awa, wd, awv, wv, bre} <= {a, d, 3'b111};
         for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (aw_r) awv <= 1'b0;
            if (w_r) wv <= 1'b0;
            if (bv) break;
         end
         wrsp = br;
         bre <= 1'b0;
         if (i == 50) tmo;
      end
   endtask
   task rdr(input [9:0] a);
      int i;
      begin
         @(posedge clk);
         {ara, arv, rre} <= {a, 2'b11};
         for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (ar_r) arv <= 1'b0;
            if (rv) break;
         end
         {rd, rr} = {rdat, rrs};
         {arv, rre} <= 2'b00;
         if (i == 50) tmo;
      end
   endtask
   // debug selection leaves the address unchecked
   task xl(input [15:0] a, input d, input f, input [17:0] g, input [2:0] s);
      begin
         u_pmt_master_model.access(a, d, f);
         #1;
         chk("sel", cs, s);
         if (s !== `PMT_SEL_DEBUG) chk("gaddr", cg, g);
         chk("dbg_valid", dov, 1);
      end
   endtask
   task rst;
      begin
         rst_n <= 1'b0;
         repeat (4) @(posedge clk);
         rst_n <= 1'b1;
         @(posedge clk);
      end
   endtask
   initial begin
      {rst_n, awv, wv, bre, arv, rre, spm, dact, drc, dwc, dcmd} = 11'h000;
      {awa, ara, wd} = 52'h0;
      err_count = 0;
      n_tests = 0;
      rst;
      rdr(`PMT_ADDR_ZERO_PAGE_BASE); chk("zpb", rd, 32'h0);
      rdr(`PMT_ADDR_PROG_WINDOW); chk("pwi", rd, 32'he);
      xl(16'h8123, 0, 0, 18'h38123, `PMT_SEL_PFLASH);
      xl(16'h4567, 0, 0, 18'h34567, `PMT_SEL_PFLASH);
      xl(16'hc001, 0, 0, 18'h3c001, `PMT_SEL_PFLASH);
      xl(16'h0100, 0, 0, 18'h00100, `PMT_SEL_REG);
      xl(16'h0500, 0, 0, 18'h04500, `PMT_SEL_DFLASH);
      xl(16'h1400, 0, 0, 18'h01400, `PMT_SEL_RAM);
      xl(16'h3fff, 0, 0, 18'h03fff, `PMT_SEL_RAM);
      wr(`PMT_ADDR_PROG_WINDOW, 32'hff);
      chk("bresp", wrsp, `PMT_RESP_OKAY);
      rdr(`PMT_ADDR_PROG_WINDOW); chk("pwi", rd, 32'hf);
      xl(16'hbf20, 0, 0, 18'h3ff20, `PMT_SEL_PFLASH);
      wr(`PMT_ADDR_PROG_WINDOW, 32'h5);
      xl(16'h8123, 0, 0, 18'h14123, `PMT_SEL_PFLASH);
      xl(16'hc100, 0, 0, 18'h3c100, `PMT_SEL_PFLASH);
      wr(`PMT_ADDR_ZERO_PAGE_BASE, 32'h80);
      wr(`PMT_ADDR_ZERO_PAGE_BASE, 32'h12);
      rdr(`PMT_ADDR_ZERO_PAGE_BASE); chk("zpb", rd, 32'h80);
      rdr(`PMT_ADDR_STATUS); chk("status", rd, 32'h1);
      xl(16'h0034, 1, 0, 18'h14034, `PMT_SEL_PFLASH);
      wr(`PMT_ADDR_PROG_WINDOW, 32'h1);
      xl(16'h8400, 0, 0, 18'h04400, `PMT_SEL_DFLASH);
      xl(16'h8000, 0, 0, 18'h04000, `PMT_SEL_INFO);
      wr(`PMT_ADDR_PROG_WINDOW, 32'h0);
      xl(16'h8800, 0, 0, 18'h00800, `PMT_SEL_NONE);
      chk("illegal", ill, 1);
      chk("undef", dund, 1);
      xl(16'h8800, 0, 1, 18'h00800, `PMT_SEL_NONE);
      chk("illegal", ill, 0);
      u_pmt_master_model.far(4'h3);
      #1;
      chk("far_done", fdone, 1);
      chk("far_rd", frd, 4'h3);
      rdr(`PMT_ADDR_PROG_WINDOW); chk("pwi", rd, 32'h3);
      {dact, drc} <= 2'b11;
      xl(16'hff10, 0, 0, 18'h3ff10, `PMT_SEL_DEBUG);
      @(posedge clk);
      {drc, dwc} <= 2'b01;
      wr(`PMT_ADDR_PROG_WINDOW, 32'hf);
      xl(16'hbf20, 0, 0, 18'h3ff20, `PMT_SEL_DEBUG);
      @(posedge clk);
      {drc, dwc} <= 2'b00;
      xl(16'hff10, 0, 0, 18'h3ff10, `PMT_SEL_PFLASH);
      @(posedge clk);
      {dact, dcmd} <= 2'b01;
      wr(`PMT_ADDR_DEBUG_WINDOW, 32'h13);
      xl(16'h8010, 0, 0, 18'h3c010, `PMT_SEL_PFLASH);
      chk("dbg_gaddr", dg, 18'h0c010);
      @(posedge clk);
      dcmd <= 1'b0;
      xl(16'h8010, 0, 0, 18'h3c010, `PMT_SEL_PFLASH);
      chk("dbg_gaddr", dg, 18'h3c010);
      rdr(10'h000); chk("rresp", rr, `PMT_RESP_SLVERR);
      wr(10'h000, 32'h1); chk("bresp", wrsp, `PMT_RESP_SLVERR);
      spm <= 1'b1;
      rst;
      wr(`PMT_ADDR_ZERO_PAGE_BASE, 32'h11);
      wr(`PMT_ADDR_ZERO_PAGE_BASE, 32'h22);
      rdr(`PMT_ADDR_ZERO_PAGE_BASE); chk("zpb", rd, 32'h22);
      rdr(`PMT_ADDR_STATUS); chk("status", rd, 32'h2);
      finish_test;
   end
endmodule // test_pmt_translator
